// ### src/pcg_pkg.sv
// peripheral clock gating: shared constants, register map and types
// assumes a single 200 MHz peripheral clock and an APB register master
package pcg_pkg;

	////////////////////////////////////////////////////////////////////
	// bus shape
	localparam int          REG_W    = 32;
	localparam int          NUM_REGS = 5;
	localparam int          APB_AW   = 8;
	localparam int          SEL_W    = 6;

	// register byte offsets
	localparam logic [7:0]  OFS_GATE1 = 8'h00;
	localparam logic [7:0]  OFS_GATE2 = 8'h04;
	localparam logic [7:0]  OFS_GATE3 = 8'h08;
	localparam logic [7:0]  OFS_GATE4 = 8'h0C;
	localparam logic [7:0]  OFS_GATE5 = 8'h10;

	// field positions
	localparam int          ADC_BIT      = 0;
	localparam int          VREF_BIT     = 12;
	localparam int          CMP1_BIT     = 0;
	localparam int          CMP2_BIT     = 1;
	localparam int          CAPTURE_LSB  = 0;
	localparam int          COMPOUT_LSB  = 16;
	localparam int          TIMER_LSB    = 0;
	localparam int          SERIAL1_BIT  = 0;
	localparam int          SERIAL2_BIT  = 1;
	localparam int          UNIT_COUNT   = 9;

	// reset value and implemented-bit masks
	localparam logic [31:0] GATE_RST   = 32'h0000_0000;
	localparam logic [31:0] MASK_GATE1 = 32'h0000_1001;
	localparam logic [31:0] MASK_GATE2 = 32'h0000_0003;
	localparam logic [31:0] MASK_GATE3 = 32'h01FF_01FF;
	localparam logic [31:0] MASK_GATE4 = 32'h0000_01FF;
	localparam logic [31:0] MASK_GATE5 = 32'h0000_0003;

	// flat peripheral numbering on the gate outputs
	localparam int          NUM_PERIPH = 33;
	localparam int          PID_ADC    = 0;
	localparam int          PID_VREF   = 1;
	localparam int          PID_CMP1   = 2;
	localparam int          PID_CMP2   = 3;
	localparam int          PID_CAP0   = 4;
	localparam int          PID_OCMP0  = 13;
	localparam int          PID_TMR0   = 22;
	localparam int          PID_SER1   = 31;
	localparam int          PID_SER2   = 32;

	// register slave phase
	typedef enum logic [0:0] {
		APB_IDLE   = 1'b0,
		APB_ACCESS = 1'b1
	} pcg_apb_st_t;

	typedef logic [NUM_REGS-1:0][REG_W-1:0] pcg_gate_bank_t;

endpackage : pcg_pkg

// ### src/pcg_gate_map.sv
// pcg_gate_map: spreads the disable registers onto one bit per peripheral
// assumes register bits already masked to the implemented positions
`timescale 1ns/10ps
`default_nettype none
module pcg_gate_map
	import pcg_pkg::*;
(
	input  wire pcg_pkg::pcg_gate_bank_t         gateRegs,
	output logic [pcg_pkg::NUM_PERIPH-1:0]       disableVec
);
	import pcg_pkg::*;

	////////////////////////////////////////////////////////////////////
	// single bits of registers 1, 2 and 5
	assign disableVec[PID_ADC]  = gateRegs[0][ADC_BIT];
	assign disableVec[PID_VREF] = gateRegs[0][VREF_BIT];
	assign disableVec[PID_CMP1] = gateRegs[1][CMP1_BIT];
	assign disableVec[PID_CMP2] = gateRegs[1][CMP2_BIT];
	assign disableVec[PID_SER1] = gateRegs[4][SERIAL1_BIT];
	assign disableVec[PID_SER2] = gateRegs[4][SERIAL2_BIT];

	// nine-unit groups, unit order follows bit order
	for (genvar u = 0; u < UNIT_COUNT; u++) begin : g_units
		assign disableVec[PID_CAP0 + u]  = gateRegs[2][CAPTURE_LSB + u];
		assign disableVec[PID_OCMP0 + u] = gateRegs[2][COMPOUT_LSB + u];
		assign disableVec[PID_TMR0 + u]  = gateRegs[3][TIMER_LSB + u];
	end

endmodule : pcg_gate_map
`default_nettype wire

// ### src/pcg_clk_en_cell.sv
// pcg_clk_en_cell: registered clock enable for one peripheral
// assumes the peripheral gates its own clock tree on this level
`timescale 1ns/10ps
`default_nettype none
module pcg_clk_en_cell (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic disableIn,
	output logic      clkEn
);
	typedef struct packed {
		logic en;
	} pcg_cell_st_t;

	pcg_cell_st_t st_r;
	pcg_cell_st_t st_nxt;

	////////////////////////////////////////////////////////////////////
	// enable is the inverse of the disable bit, one cycle later
	always_comb begin
		st_nxt    = st_r;
		st_nxt.en = ~disableIn;
	end

	// reset leaves the peripheral clocked
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r <= '{en: 1'b1};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign clkEn = st_r.en;

endmodule : pcg_clk_en_cell
`default_nettype wire

// ### src/pcg_top.sv
// pcg_top: peripheral disable registers on APB, clock enables and
// an access filter in front of the peripherals' own registers
// assumes APB master and peripheral bus on clk; no pin inputs
`timescale 1ns/10ps
`default_nettype none
module pcg_top
	import pcg_pkg::*;
#(
	parameter int ADDR_W = APB_AW
) (
	input  wire logic                          clk,
	input  wire logic                          rst,
	// register bus
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [ADDR_W-1:0]             paddr,
	input  wire logic [pcg_pkg::REG_W-1:0]     pwdata,
	input  wire logic [3:0]                    pstrb,
	output logic [pcg_pkg::REG_W-1:0]          prdata,
	output logic                               pready,
	output logic                               pslverr,
	// peripheral register access from the core side
	input  wire logic                          accReq,
	input  wire logic                          accWrite,
	input  wire logic [pcg_pkg::SEL_W-1:0]     accSel,
	input  wire logic [7:0]                    accAddr,
	input  wire logic [pcg_pkg::REG_W-1:0]     accWdata,
	input  wire logic [pcg_pkg::REG_W-1:0]     accRdataIn,
	// forwarded access towards the peripherals
	output logic                               fwdWrite,
	output logic                               fwdRead,
	output logic [pcg_pkg::SEL_W-1:0]          fwdSel,
	output logic [7:0]                         fwdAddr,
	output logic [pcg_pkg::REG_W-1:0]          fwdWdata,
	output logic [pcg_pkg::REG_W-1:0]          accRdata,
	output logic                               accRvalid,
	output logic                               accBlocked,
	// per-peripheral gate state
	output logic [pcg_pkg::NUM_PERIPH-1:0]     periphClkEn,
	output logic [pcg_pkg::NUM_PERIPH-1:0]     periphDisable
);
	import pcg_pkg::*;

	////////////////////////////////////////////////////////////////////
	// elaboration checks

	if (ADDR_W < 5) begin : g_bad_aw
		$error("pcg_top: ADDR_W too small for the register map");
	end
	if ((1 << SEL_W) < NUM_PERIPH) begin : g_bad_sel
		$error("pcg_top: SEL_W cannot number every peripheral");
	end

	////////////////////////////////////////////////////////////////////
	// decode helpers

	// word index of a byte address, NUM_REGS when unmapped or misaligned
	function automatic logic [2:0] regIndex(input logic [ADDR_W-1:0] a);
		logic [7:0] ofs;
		ofs = 8'(a);
		if (a != ADDR_W'(ofs) || ofs[1:0] != 2'b00) begin
			return 3'(NUM_REGS);
		end
		unique case (ofs)
			OFS_GATE1: return 3'd0;
			OFS_GATE2: return 3'd1;
			OFS_GATE3: return 3'd2;
			OFS_GATE4: return 3'd3;
			OFS_GATE5: return 3'd4;
			default:   return 3'(NUM_REGS);
		endcase
	endfunction : regIndex

	// implemented bits of each register
	function automatic logic [REG_W-1:0] regMask(input logic [2:0] idx);
		unique case (idx)
			3'd0:    return MASK_GATE1;
			3'd1:    return MASK_GATE2;
			3'd2:    return MASK_GATE3;
			3'd3:    return MASK_GATE4;
			3'd4:    return MASK_GATE5;
			default: return 32'h0000_0000;
		endcase
	endfunction : regMask

	// byte-lane merge of a write into the old value
	function automatic logic [REG_W-1:0] laneMerge(
		input logic [REG_W-1:0] oldVal,
		input logic [REG_W-1:0] newVal,
		input logic [3:0]       strb
	);
		logic [REG_W-1:0] res;
		res = oldVal;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = newVal[8*b +: 8];
			end
		end
		return res;
	endfunction : laneMerge

	////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		pcg_gate_bank_t   gate;
		pcg_apb_st_t      apbSt;
		logic [2:0]       wrIdx;
		logic [REG_W-1:0] prdata;
		logic             pready;
		logic             pslverr;
		logic             fwdWrite;
		logic             fwdRead;
		logic [SEL_W-1:0] fwdSel;
		logic [7:0]       fwdAddr;
		logic [REG_W-1:0] fwdWdata;
		logic             rdPend;
		logic [SEL_W-1:0] rdSel;
		logic [REG_W-1:0] accRdata;
		logic             accRvalid;
		logic             accBlocked;
	} pcg_top_st_t;

	pcg_top_st_t             st_r;
	pcg_top_st_t             st_nxt;
	logic [NUM_PERIPH-1:0]   disVec;
	logic                    selOff;
	logic                    pendOff;
	logic [2:0]              setupIdx;

	////////////////////////////////////////////////////////////////////
	// disable bit map and clock enable cells

	pcg_gate_map u_map (
		.gateRegs   (st_r.gate),
		.disableVec (disVec)
	);

	for (genvar p = 0; p < NUM_PERIPH; p++) begin : g_cells
		pcg_clk_en_cell u_cell (
			.clk       (clk),
			.rst       (rst),
			.disableIn (disVec[p]),
			.clkEn     (periphClkEn[p])
		);
	end

	// selects beyond the peripheral count are treated as disabled
	assign selOff   = (32'(accSel) >= NUM_PERIPH) ? 1'b1 : disVec[accSel];
	assign pendOff  = (32'(st_r.rdSel) >= NUM_PERIPH) ? 1'b1 : disVec[st_r.rdSel];
	assign setupIdx = regIndex(paddr);

	////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		st_nxt = st_r;

		// register slave: answer in the first access cycle
		st_nxt.pready = 1'b0;
		unique case (st_r.apbSt)
			APB_IDLE: begin
				if (psel && !penable) begin
					st_nxt.apbSt   = APB_ACCESS;
					st_nxt.pready  = 1'b1;
					st_nxt.wrIdx   = setupIdx;
					st_nxt.pslverr = (setupIdx == 3'(NUM_REGS));
					st_nxt.prdata  = 32'h0000_0000;
					if (!pwrite && setupIdx != 3'(NUM_REGS)) begin
						st_nxt.prdata = st_r.gate[setupIdx];
					end
				end
			end
			APB_ACCESS: begin
				// write lands at the edge that samples pready high
				if (psel && penable && pwrite && !st_r.pslverr) begin
					st_nxt.gate[st_r.wrIdx] =
						laneMerge(st_r.gate[st_r.wrIdx], pwdata, pstrb)
						& regMask(st_r.wrIdx);
				end
				st_nxt.apbSt   = APB_IDLE;
				st_nxt.pslverr = 1'b0;
				st_nxt.prdata  = 32'h0000_0000;
			end
		endcase

		// peripheral access filter, one cycle to forward
		st_nxt.fwdWrite   = 1'b0;
		st_nxt.fwdRead    = 1'b0;
		st_nxt.accBlocked = 1'b0;
		st_nxt.rdPend     = 1'b0;
		if (accReq) begin
			st_nxt.fwdSel  = accSel;
			st_nxt.fwdAddr = accAddr;
			if (selOff) begin
				// no strobe reaches a stopped peripheral
				st_nxt.accBlocked = 1'b1;
			end else begin
				st_nxt.fwdWrite = accWrite;
				st_nxt.fwdRead  = !accWrite;
			end
			if (accWrite) begin
				st_nxt.fwdWdata = accWdata;
			end else begin
				st_nxt.rdPend = 1'b1;
				st_nxt.rdSel  = accSel;
			end
		end

		// read answer one cycle after forwarding; zero when stopped
		st_nxt.accRvalid = st_r.rdPend;
		st_nxt.accRdata  = 32'h0000_0000;
		if (st_r.rdPend && !pendOff) begin
			st_nxt.accRdata = accRdataIn;
		end
	end

	////////////////////////////////////////////////////////////////////
	// state register; all gate bits clear on reset

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r            <= '0;
			st_r.gate       <= {NUM_REGS{GATE_RST}};
			st_r.apbSt      <= APB_IDLE;
			st_r.wrIdx      <= 3'(NUM_REGS);
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs

	assign prdata        = st_r.prdata;
	assign pready        = st_r.pready;
	assign pslverr       = st_r.pslverr;
	assign fwdWrite      = st_r.fwdWrite;
	assign fwdRead       = st_r.fwdRead;
	assign fwdSel        = st_r.fwdSel;
	assign fwdAddr       = st_r.fwdAddr;
	assign fwdWdata      = st_r.fwdWdata;
	assign accRdata      = st_r.accRdata;
	assign accRvalid     = st_r.accRvalid;
	assign accBlocked    = st_r.accBlocked;
	assign periphDisable = disVec;

	////////////////////////////////////////////////////////////////////
	// checks

	a_reset_clear: assert property (
		@(posedge clk) disable iff (rst)
		$fell(rst) |-> (st_r.gate == '0) && (&periphClkEn))
		else $error("gate bits not clear after reset");

	a_clock_stop: assert property (
		@(posedge clk) disable iff (rst)
		$stable(disVec) |=> (periphClkEn == ~$past(disVec)))
		else $error("clock enable disagrees with disable bit");

	a_write_lands: assert property (
		@(posedge clk) disable iff (rst)
		(psel && penable && pready && pwrite && !pslverr
			&& pstrb == 4'hF && paddr == ADDR_W'(OFS_GATE4))
		|=> st_r.gate[3] == ($past(pwdata) & MASK_GATE4))
		else $error("register write did not land");

	a_unused_zero: assert property (
		@(posedge clk) disable iff (rst)
		((st_r.gate[0] & ~MASK_GATE1) == '0)
		&& ((st_r.gate[2] & ~MASK_GATE3) == '0)
		&& ((st_r.gate[4] & ~MASK_GATE5) == '0))
		else $error("unlisted gate bit set");

	a_apb_answer: assert property (
		@(posedge clk) disable iff (rst)
		(psel && !penable) |=> pready ##1 !pready)
		else $error("register slave answer not one cycle");

	a_block_write: assert property (
		@(posedge clk) disable iff (rst)
		(accReq && accWrite && selOff) |=> accBlocked && !fwdWrite)
		else $error("write reached a disabled peripheral");

	a_pass_write: assert property (
		@(posedge clk) disable iff (rst)
		(accReq && accWrite && !selOff)
		|=> fwdWrite && fwdWdata == $past(accWdata) && !accBlocked)
		else $error("write to enabled peripheral lost");

	a_read_zero: assert property (
		@(posedge clk) disable iff (rst)
		(st_r.rdPend && pendOff) |=> accRvalid && accRdata == '0)
		else $error("disabled read returned data");

	a_map_vref: assert property (
		@(posedge clk) disable iff (rst)
		periphDisable[PID_VREF] == st_r.gate[0][VREF_BIT])
		else $error("vref gate bit misplaced");

	a_map_compout: assert property (
		@(posedge clk) disable iff (rst)
		periphDisable[PID_OCMP0+8] == st_r.gate[2][COMPOUT_LSB+8])
		else $error("compare output gate bit misplaced");

	a_map_timer: assert property (
		@(posedge clk) disable iff (rst)
		periphDisable[PID_TMR0+8] == st_r.gate[3][TIMER_LSB+8])
		else $error("timer gate bit misplaced");

	a_map_serial: assert property (
		@(posedge clk) disable iff (rst)
		periphDisable[PID_SER2] == st_r.gate[4][SERIAL2_BIT]
		&& periphDisable[PID_CMP2] == st_r.gate[1][CMP2_BIT])
		else $error("serial or comparator gate bit misplaced");

	a_map_capture: assert property (
		@(posedge clk) disable iff (rst)
		periphDisable[PID_CAP0+8] == st_r.gate[2][CAPTURE_LSB+8])
		else $error("capture gate bit misplaced");

	a_block_read: assert property (
		@(posedge clk) disable iff (rst)
		(accReq && !accWrite && selOff) |=> accBlocked && !fwdRead)
		else $error("read reached a disabled peripheral");

	a_pass_read: assert property (
		@(posedge clk) disable iff (rst)
		(st_r.rdPend && !pendOff) |=> accRvalid && accRdata == $past(accRdataIn))
		else $error("read from enabled peripheral lost");

	a_bad_addr: assert property (
		@(posedge clk) disable iff (rst)
		(psel && !penable && setupIdx == 3'(NUM_REGS)) |=> pready && pslverr && prdata == '0)
		else $error("unmapped address not refused");

	a_map_adc: assert property (
		@(posedge clk) disable iff (rst)
		periphDisable[PID_ADC] == st_r.gate[0][ADC_BIT]
		&& periphDisable[PID_CMP1] == st_r.gate[1][CMP1_BIT])
		else $error("adc or comparator gate bit misplaced");

	// software ordering of on bits (and usb idle) is the caller's duty;
	// this block cannot see a peripheral's own on bit

endmodule : pcg_top
`default_nettype wire

// ### sim/pcg_periph_model.sv
// pcg_periph_model: stand-in for the gated peripherals' register files
// assumes forwarded strobes from pcg_top on the same clock
`timescale 1ns/10ps
`default_nettype none
module pcg_periph_model (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        fwdRead,
	input  wire logic        fwdWrite,
	input  wire logic [5:0]  fwdSel,
	input  wire logic [7:0]  fwdAddr,
	output logic [31:0]      accRdataIn,
	output var int           writeCount
);
	logic [31:0] rdWord;
	// word built from unit and offset, so a wrong select shows up
	assign rdWord = {2'b10, fwdSel, fwdAddr, 16'hC35A};
	// outside a read the bus shows the inverse, never stale data
	assign accRdataIn = fwdRead ? rdWord : ~rdWord;
	// count landed writes; a blocked one must never arrive here
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			writeCount <= 0;
		end else if (fwdWrite) begin
			writeCount <= writeCount + 1;
		end
	end
endmodule : pcg_periph_model
`default_nettype wire

// ### sim/peripheral_clock_gating_bench.sv
// peripheral_clock_gating_bench: self-checking bench for pcg_top
// assumes pcg_pkg, pcg_top and pcg_periph_model compiled first
`timescale 1ns/10ps
`default_nettype none
module peripheral_clock_gating_bench;
	import pcg_pkg::*;
	logic        clk, rst, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, accAddr, fwdAddr;
	logic [31:0] pwdata, prdata, accWdata, accRdataIn, fwdWdata, accRdata;
	logic [3:0]  pstrb;
	logic        accReq, accWrite, fwdWrite, fwdRead, accRvalid, accBlocked;
	logic [5:0]  accSel, fwdSel;
	logic [32:0] periphClkEn, periphDisable;
	int          err_count, checked, writeCount;

	////////////////////////////////////////////////////////////////////
	pcg_top u_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .accReq, .accWrite, .accSel, .accAddr,
		.accWdata, .accRdataIn, .fwdWrite, .fwdRead, .fwdSel, .fwdAddr,
		.fwdWdata, .accRdata, .accRvalid, .accBlocked, .periphClkEn,
		.periphDisable);
	pcg_periph_model u_periph (.clk, .rst, .fwdRead, .fwdWrite, .fwdSel,
		.fwdAddr, .accRdataIn, .writeCount);

	////////////////////////////////////////////////////////////////////
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk

	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic e);
		int n;
		@(posedge clk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			err_count++;
			$display("Error at %0t: no pready", $time);
			report_and_stop();
		end
		rd = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// one filtered access; strobes one cycle, read data one more
	task automatic acc(input logic wr, input logic [5:0] sel, input logic blk);
		int wc;
		logic [31:0] expRd;
		wc = writeCount;
		@(posedge clk);
		accReq   <= 1'b1;
		accWrite <= wr;
		accSel   <= sel;
		@(posedge clk);
		accReq   <= 1'b0;
		@(posedge clk);
		chk(accBlocked, blk, "blocked flag");
		chk(wr ? fwdWrite : fwdRead, !blk, "forward strobe");
		if (!blk) chk(fwdSel, sel, "forward select");
		if (!blk && wr) chk(fwdWdata, accWdata, "forward data");
		@(posedge clk);
		chk(writeCount, wc + (wr && !blk), "landed writes");
		if (!wr) chk(accRvalid, 1'b1, "read valid");
		expRd = blk ? 32'h0 : {2'b10, sel, accAddr, 16'hC35A};
		if (!wr) chk(accRdata, expRd, "read data");
	endtask : acc

	////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		logic [31:0] rd;
		logic e;
		chk(periphClkEn, {33{1'b1}}, "reset clock enables");
		chk(periphDisable, 33'h0, "reset disables");
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, 8'(i * 4), 32'h0, rd, e);
			chk(rd, 32'h0, "reset register");
		end
		$display("test reset done");
	endtask : t_reset

	task automatic t_map;
		int regTab[12] = '{0, 0, 1, 1, 2, 2, 2, 2, 3, 3, 4, 4};
		int bitTab[12] = '{0, 12, 0, 1, 0, 8, 16, 24, 0, 8, 0, 1};
		int pidTab[12] = '{0, 1, 2, 3, 4, 12, 13, 21, 22, 30, 31, 32};
		logic [32:0] oneHot;
		logic [31:0] rd;
		logic e;
		for (int i = 0; i < 12; i++) begin
			apb(1'b1, 8'(regTab[i] * 4), 32'h1 << bitTab[i], rd, e);
			oneHot = 33'h1 << pidTab[i];
			@(posedge clk);
			chk(periphDisable, oneHot, "bit place");
			@(posedge clk);
			chk(periphClkEn, ~oneHot, "clock stopped");
			apb(1'b1, 8'(regTab[i] * 4), 32'h0, rd, e);
		end
		$display("test map done");
	endtask : t_map

	task automatic t_mask;
		logic [31:0] maskTab[5] = '{32'h0000_1001, 32'h0000_0003, 32'h01FF_01FF,
			32'h0000_01FF, 32'h0000_0003};
		logic [31:0] rd;
		logic e;
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, 8'(i * 4), 32'hFFFF_FFFF, rd, e);
			apb(1'b0, 8'(i * 4), 32'h0, rd, e);
			chk(rd, maskTab[i], "implemented bits");
			chk(e, 1'b0, "no error");
		end
		@(posedge clk);
		chk(periphDisable, {33{1'b1}}, "all disabled");
		for (int i = 0; i < 5; i++) apb(1'b1, 8'(i * 4), 32'h0, rd, e);
		// one byte lane only; lane 2 holds compare outputs 0 to 7
		pstrb <= 4'h4;
		apb(1'b1, OFS_GATE3, 32'hFFFF_FFFF, rd, e);
		pstrb <= 4'hF;
		apb(1'b0, OFS_GATE3, 32'h0, rd, e);
		chk(rd, 32'h00FF_0000 & MASK_GATE3, "lane write");
		apb(1'b1, OFS_GATE3, 32'h0, rd, e);
		$display("test mask done");
	endtask : t_mask

	task automatic t_bad_addr;
		logic [31:0] rd;
		logic e;
		apb(1'b0, 8'h14, 32'h0, rd, e);
		chk(e, 1'b1, "unmapped error");
		chk(rd, 32'h0, "unmapped data");
		apb(1'b1, 8'h02, 32'hFFFF_FFFF, rd, e);
		chk(e, 1'b1, "misaligned error");
		apb(1'b0, 8'h00, 32'h0, rd, e);
		chk(rd, 32'h0, "misaligned write ignored");
		$display("test bad address done");
	endtask : t_bad_addr

	task automatic t_filter;
		logic [31:0] rd;
		logic e;
		acc(1'b0, 6'd5, 1'b0);
		acc(1'b1, 6'd5, 1'b0);
		// model units are never switched on, and no usb gate exists here
		apb(1'b1, 8'h08, 32'h0000_0002, rd, e);
		acc(1'b1, 6'd5, 1'b1);
		acc(1'b0, 6'd5, 1'b1);
		acc(1'b0, 6'd4, 1'b0);
		acc(1'b1, 6'd40, 1'b1);
		apb(1'b1, 8'h08, 32'h0, rd, e);
		acc(1'b1, 6'd5, 1'b0);
		$display("test filter done");
	endtask : t_filter

	// reset in mid-run must clear bits already set
	task automatic t_mid_reset;
		logic [31:0] rd;
		logic e;
		apb(1'b1, OFS_GATE4, 32'h0000_01FF, rd, e);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		chk(periphDisable, 33'h0, "mid reset disables");
		chk(periphClkEn, {33{1'b1}}, "mid reset enables");
		apb(1'b0, OFS_GATE4, 32'h0, rd, e);
		chk(rd, 32'h0, "mid reset register");
		$display("test mid reset done");
	endtask : t_mid_reset

	////////////////////////////////////////////////////////////////////
	// free-running clock, 5 ns period
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// main sequence: inputs quiet at time zero, reset for two cycles
	initial begin
		rst = 1'b1;
		{psel, penable, pwrite, accReq, accWrite} = '0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'hF;
		accSel = 6'd0;
		accAddr = 8'h3C;
		accWdata = 32'h1234_5678;
		err_count = 0;
		checked = 0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_map();
		t_mask();
		t_bad_addr();
		t_filter();
		t_mid_reset();
		report_and_stop();
	end
endmodule : peripheral_clock_gating_bench
`default_nettype wire
